// >>> vcd_cfg.svh
`ifndef VCD_CFG_SVH
`define VCD_CFG_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define VCD_OFS_STATUS      16'he502
`define VCD_OFS_MASK        16'he50a
`define VCD_OFS_SETUP       16'he618
`define VCD_OFS_GAIN_BASE   16'h43a0
`define VCD_OFS_SAMPLE_BASE 16'he520
`define VCD_NUM_CHAN        8

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define VCD_READY_BIT       17
`define VCD_HPF_EN_BIT      4
`define VCD_PIN_FN_LSB      0
`define VCD_ROUTE_A_LSB     8
`define VCD_ROUTE_B_LSB     10
`define VCD_ROUTE_C_LSB     12
`define VCD_SETUP_RESET     16'h0010
`define VCD_GAIN_FRAC_BITS  23
`define VCD_HPF_SHIFT       10

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define VCD_CLK_PERIOD_NS   10
`define VCD_READY_DELAY_NS  70
`define VCD_READY_LOW_US    10
`define VCD_READY_DELAY_CYC (`VCD_READY_DELAY_NS / `VCD_CLK_PERIOD_NS)
`define VCD_READY_LOW_CYC   ((`VCD_READY_LOW_US * 1000 + `VCD_CLK_PERIOD_NS - 1) / `VCD_CLK_PERIOD_NS)

`endif

// >>> vcd_chan.sv
`timescale 1ns/1ps
`include "vcd_cfg.svh"

module vcd_chan (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        in_valid,
    input  wire logic [23:0] in_sample,
    input  wire logic [23:0] gain,
    input  wire logic        hpf_en,
    output logic             out_valid,
    output logic [23:0]      out_sample
);
    import vcd_pkg::*;

    vcd_chan_state_t st;        // Registered state
    vcd_chan_state_t next_st;   // Next state
    logic signed [47:0] prod;   // Sample times gain
    logic signed [25:0] scaled; // Sample plus scaled product
    logic signed [23:0] gained; // Saturated gained sample
    logic signed [32:0] diff;   // Input minus dc estimate
    logic signed [24:0] hp;     // Filter output before saturation

    // ------------------------------------------------------------
    // Gain and dc removal
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        prod    = $signed(in_sample) * $signed(gain);
        // Scale by one plus gain over two to the 23rd
        scaled  = 26'($signed(in_sample)) + 26'(prod >>> `VCD_GAIN_FRAC_BITS);
        if (scaled > 26'sd8388607) begin
            gained = 24'sh7fffff;
        end else if (scaled < -26'sd8388608) begin
            gained = 24'sh800000;
        end else begin
            gained = scaled[23:0];
        end
        // Keep the sign of the scaled input so negative levels track down
        diff = 33'($signed({gained, 8'h00})) - 33'($signed(st.dc));
        hp   = 25'(gained) - 25'($signed(st.dc[31:8]));
        next_st.valid = in_valid;
        if (in_valid) begin
            if (hpf_en) begin
                // First order dc tracker removes offset
                next_st.dc = st.dc + 32'(diff >>> `VCD_HPF_SHIFT);
                if (hp > 25'sd8388607) begin
                    next_st.sample = 24'h7fffff;
                end else if (hp < -25'sd8388608) begin
                    next_st.sample = 24'h800000;
                end else begin
                    next_st.sample = hp[23:0];
                end
            end else begin
                // Bypass passes gained sample straight on
                next_st.dc     = 32'h0000_0000;
                next_st.sample = gained;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign out_valid  = st.valid;
    assign out_sample = st.sample;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_UNITY_GAIN: assert property (@(posedge clk) disable iff (!rst_n)
        in_valid && !hpf_en && gain == 24'h000000 |=> out_sample == $past(in_sample))
        else $error("unity gain bypass changed the sample");
    AST_BYPASS: assert property (@(posedge clk) disable iff (!rst_n)
        in_valid && !hpf_en |=> out_valid && st.dc == 32'h0000_0000)
        else $error("bypass left a dc stage active");

endmodule : vcd_chan

// >>> vcd_host_model.sv
`timescale 1ns/1ps
`include "vcd_cfg.svh"

module vcd_host_model (
    input  wire logic              clk,
    input  wire vcd_pkg::vcd_rsp_t rsp,
    output vcd_pkg::vcd_req_t      req
);
    import vcd_pkg::*;

    // ------------------------------------------------------------
    // Host side of the register port
    // ------------------------------------------------------------
    // Idle port starts low; valid is what matters
    initial begin
        req = '0;
    end

    // One request, held over the taking edge, then released with
    // inverted leftovers so a stale address can never pass for a live one
    task automatic drive(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(negedge clk);
        req <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    endtask : drive

    // Read: answer stands in the cycle after the taking edge
    task automatic read_reg(input logic [15:0] a, output logic [31:0] d, output logic v);
        drive(1'b0, a, 32'h0000_0000);
        d = rsp.data;
        v = rsp.valid;
    endtask : read_reg

    // Burst of all eight sample words, started once the ready pin rose
    task automatic burst_read(output logic [7:0][31:0] words);
        logic v;
        for (int c = 0; c < `VCD_NUM_CHAN; c++) begin
            read_reg(`VCD_OFS_SAMPLE_BASE + 16'(c), words[c], v);
        end
    endtask : burst_read

endmodule : vcd_host_model

// >>> vcd_pkg.sv
package vcd_pkg;

    // Eight channel words: A, A2, B, B2, C, C2, N, N2
    typedef logic [7:0][23:0] vcd_words_t;

    // Converter samples arriving together at 8 kSPS
    typedef struct packed {
        logic       valid;
        vcd_words_t samples;
    } vcd_adc_t;

    // Register request from the serial port engine
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } vcd_req_t;

    // Read answer
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } vcd_rsp_t;

    // Voltages handed to the per-phase power computations
    typedef struct packed {
        logic        valid;
        logic [23:0] a;
        logic [23:0] b;
        logic [23:0] c;
    } vcd_path_t;

    // Ready pin sequencer
    typedef enum logic [1:0] {
        VCD_PIN_IDLE = 2'b00,
        VCD_PIN_WAIT = 2'b01,
        VCD_PIN_LOW  = 2'b10
    } vcd_pin_state_t;

    // Channel state
    typedef struct packed {
        logic        valid;
        logic [23:0] sample;
        logic [31:0] dc;
    } vcd_chan_state_t;

    // Top state
    typedef struct packed {
        logic           ready_flag;
        logic [31:0]    mask;
        logic [15:0]    setup;
        vcd_words_t     gains;
        vcd_words_t     samples;
        vcd_rsp_t       rsp;
        vcd_path_t      path;
        logic           irq_n;
        logic           pin_n;
        vcd_pin_state_t pin_st;
        logic [10:0]    pin_cnt;
    } vcd_state_t;

endpackage : vcd_pkg

// >>> vcd_top.sv
`timescale 1ns/1ps
`include "vcd_cfg.svh"

// How it works
// - Scale sample by one plus gain fraction
// - Gain applies to every derived result
// - Gain reads sign-extend to 28, zero pad
// - Setup bit 4 enables all dc filters
// - Store filter outputs as 24-bit samples
// - Sample storage never stalls the computations
// - Set ready flag when samples stored
// - Masked ready flag drives interrupt low
// - Field 00: pin low 70 ns later
// - Pin stays low 10 us, then high
// - Samples read as sign-extended 32-bit words
// - Any phase voltage routes into another path
// - Phase A route field selects A,B,C,A
// - Phase B route field selects B,C,A,B
// - Phase C route field selects C,A,B,C
// - Writing one clears flag, releases interrupt

module vcd_top (
    input  wire logic           clk,
    input  wire logic           rstn,
    input  wire vcd_pkg::vcd_adc_t adc,
    input  wire vcd_pkg::vcd_req_t req,
    output vcd_pkg::vcd_rsp_t   rsp,
    output vcd_pkg::vcd_path_t  path,
    output logic                first_interrupt_output_n,
    output logic                shared_ready_pin_n
);
    import vcd_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_q;          // Release synchroniser
    logic       rst_sync_n;     // Synchronised reset

    // Two stage release, assertion stays asynchronous
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_q[1];

    // ------------------------------------------------------------
    // Channel datapaths
    // ------------------------------------------------------------
    vcd_state_t st;             // Registered state
    vcd_state_t next_st;        // Next state
    logic [7:0] chan_valid;     // Per channel result strobe
    vcd_words_t chan_out;       // Per channel filtered sample
    logic       hpf_en;         // Filter enable from setup word

    assign hpf_en = st.setup[`VCD_HPF_EN_BIT];

    // One gain and filter stage per channel
    for (genvar i = 0; i < `VCD_NUM_CHAN; i++) begin : g_chan
        vcd_chan u_chan (
            .clk        (clk),
            .rst_n      (rst_sync_n),
            .in_valid   (adc.valid),
            .in_sample  (adc.samples[i]),
            .gain       (st.gains[i]),
            .hpf_en     (hpf_en),
            .out_valid  (chan_valid[i]),
            .out_sample (chan_out[i])
        );
    end

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Route selection; code 11 falls back to own phase
    function automatic logic [23:0] vcd_route(
        input logic [1:0]  sel,
        input logic [23:0] own,
        input logic [23:0] one,
        input logic [23:0] two
    );
        logic [23:0] res;
        res = own;
        if (sel == 2'b01) begin
            res = one;
        end else if (sel == 2'b10) begin
            res = two;
        end
        return res;
    endfunction : vcd_route

    // ------------------------------------------------------------
    // Request decode and datapath control
    // ------------------------------------------------------------
    logic        wr;            // Write request
    logic        rd;            // Read request
    logic        gain_hit;      // Address hits a gain register
    logic        smp_hit;       // Address hits a sample register
    logic [2:0]  idx;           // Channel index within a bank
    logic        set_ready;     // New sample set stored
    logic        clr_ready;     // Write one to ready flag
    logic [15:0] gain_ofs;      // Offset into gain bank
    logic [15:0] smp_ofs;       // Offset into sample bank

    always_comb begin
        wr       = req.valid && req.write;
        rd       = req.valid && !req.write;
        gain_ofs = req.addr - `VCD_OFS_GAIN_BASE;
        smp_ofs  = req.addr - `VCD_OFS_SAMPLE_BASE;
        gain_hit = (req.addr >= `VCD_OFS_GAIN_BASE)
                   && (gain_ofs < 16'(`VCD_NUM_CHAN));
        smp_hit  = (req.addr >= `VCD_OFS_SAMPLE_BASE)
                   && (smp_ofs < 16'(`VCD_NUM_CHAN));
        idx      = gain_hit ? gain_ofs[2:0] : smp_ofs[2:0];
        set_ready = &chan_valid;
        clr_ready = wr && (req.addr == `VCD_OFS_STATUS)
                    && req.wdata[`VCD_READY_BIT];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Register writes
        if (wr) begin
            if (req.addr == `VCD_OFS_MASK) begin
                next_st.mask = req.wdata;
            end else if (req.addr == `VCD_OFS_SETUP) begin
                next_st.setup = req.wdata[15:0];
            end else if (gain_hit) begin
                next_st.gains[idx] = req.wdata[23:0];
            end
        end

        // Register reads, answered one cycle later
        next_st.rsp.valid = rd;
        next_st.rsp.data  = 32'h0000_0000;
        if (rd) begin
            if (req.addr == `VCD_OFS_STATUS) begin
                next_st.rsp.data[`VCD_READY_BIT] = st.ready_flag;
            end else if (req.addr == `VCD_OFS_MASK) begin
                next_st.rsp.data = st.mask;
            end else if (req.addr == `VCD_OFS_SETUP) begin
                next_st.rsp.data = {16'h0000, st.setup};
            end else if (gain_hit) begin
                // Sign extend to 28 bits, four zeros on top
                next_st.rsp.data = {4'h0, {4{st.gains[idx][23]}}, st.gains[idx]};
            end else if (smp_hit) begin
                // Sign extend to a full 32-bit word
                next_st.rsp.data = {{8{st.samples[idx][23]}}, st.samples[idx]};
            end
        end

        // Sample store and routed paths, free running
        next_st.path.valid = set_ready;
        if (set_ready) begin
            next_st.samples = chan_out;
            // Phase A path: A, B, C, A
            next_st.path.a = vcd_route(st.setup[`VCD_ROUTE_A_LSB +: 2],
                                       chan_out[0], chan_out[2], chan_out[4]);
            // Phase B path: B, C, A, B
            next_st.path.b = vcd_route(st.setup[`VCD_ROUTE_B_LSB +: 2],
                                       chan_out[2], chan_out[4], chan_out[0]);
            // Phase C path: C, A, B, C
            next_st.path.c = vcd_route(st.setup[`VCD_ROUTE_C_LSB +: 2],
                                       chan_out[4], chan_out[0], chan_out[2]);
        end

        // Ready flag: a new set wins over a clear
        if (set_ready) begin
            next_st.ready_flag = 1'b1;
        end else if (clr_ready) begin
            next_st.ready_flag = 1'b0;
        end

        // Interrupt follows flag gated by mask
        next_st.irq_n = !(next_st.ready_flag && next_st.mask[`VCD_READY_BIT]);

        // Ready pin sequencer
        case (st.pin_st)
            VCD_PIN_IDLE: begin
                next_st.pin_n = 1'b1;
            end
            VCD_PIN_WAIT: begin
                // Count out the short delay after the flag
                next_st.pin_cnt = st.pin_cnt - 11'd1;
                if (st.pin_cnt == 11'd1) begin
                    next_st.pin_n   = 1'b0;
                    next_st.pin_st  = VCD_PIN_LOW;
                    next_st.pin_cnt = 11'(`VCD_READY_LOW_CYC);
                end
            end
            VCD_PIN_LOW: begin
                // Hold low for the pulse width, then release
                next_st.pin_cnt = st.pin_cnt - 11'd1;
                if (st.pin_cnt == 11'd1) begin
                    next_st.pin_n  = 1'b1;
                    next_st.pin_st = VCD_PIN_IDLE;
                end
            end
            default: begin
                next_st.pin_n  = 1'b1;
                next_st.pin_st = VCD_PIN_IDLE;
            end
        endcase

        // New set restarts the pulse when the pin shows ready
        if (set_ready && st.setup[`VCD_PIN_FN_LSB +: 2] == 2'b00) begin
            next_st.pin_n   = 1'b1;
            next_st.pin_st  = VCD_PIN_WAIT;
            next_st.pin_cnt = 11'(`VCD_READY_DELAY_CYC);
        end else if (st.setup[`VCD_PIN_FN_LSB +: 2] != 2'b00) begin
            // Other pin functions are not served here; pin idles high
            next_st.pin_n  = 1'b1;
            next_st.pin_st = VCD_PIN_IDLE;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st        <= '0;
            st.setup  <= `VCD_SETUP_RESET;
            st.irq_n  <= 1'b1;
            st.pin_n  <= 1'b1;
            st.pin_st <= VCD_PIN_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign rsp                      = st.rsp;
    assign path                     = st.path;
    assign first_interrupt_output_n = st.irq_n;
    assign shared_ready_pin_n       = st.pin_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [10:0] low_len;       // Length of the current low pulse

    // Count cycles with the pin low
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            low_len <= 11'd0;
        end else if (!shared_ready_pin_n) begin
            low_len <= low_len + 11'd1;
        end else begin
            low_len <= 11'd0;
        end
    end

    AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_sync_n)
        set_ready |=> st.ready_flag && st.samples == $past(chan_out))
        else $error("ready flag or samples missing after a new set");
    AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!rst_sync_n)
        clr_ready && !set_ready |=> !st.ready_flag && first_interrupt_output_n)
        else $error("write one did not clear the flag");
    AST_IRQ_LOW: assert property (@(posedge clk) disable iff (!rst_sync_n)
        set_ready && next_st.mask[17] |=> !first_interrupt_output_n)
        else $error("masked ready did not raise the interrupt");
    AST_PIN_DELAY: assert property (@(posedge clk) disable iff (!rst_sync_n)
        set_ready && st.setup[1:0] == 2'b00 && st.pin_n
        |=> shared_ready_pin_n[*7] ##1 !shared_ready_pin_n)
        else $error("ready pin did not fall 70 ns after the flag");
    AST_PIN_WIDTH: assert property (@(posedge clk) disable iff (!rst_sync_n)
        $rose(shared_ready_pin_n) && !$past(set_ready) |-> low_len == 11'd1000)
        else $error("ready pulse width wrong");
    AST_GAIN_READ: assert property (@(posedge clk) disable iff (!rst_sync_n)
        rd && gain_hit |=> rsp.valid && rsp.data[31:28] == 4'h0
        && rsp.data[27:24] == {4{rsp.data[23]}})
        else $error("gain read word malformed");
    AST_SAMPLE_READ: assert property (@(posedge clk) disable iff (!rst_sync_n)
        rd && smp_hit |=> rsp.valid && rsp.data[31:24] == {8{rsp.data[23]}})
        else $error("sample read not sign extended");
    AST_ROUTE_A: assert property (@(posedge clk) disable iff (!rst_sync_n)
        set_ready && st.setup[9:8] == 2'b01 |=> path.valid && path.a == st.samples[2])
        else $error("phase A path did not take phase B voltage");
    AST_ROUTE_B: assert property (@(posedge clk) disable iff (!rst_sync_n)
        set_ready && st.setup[11:10] == 2'b10 |=> path.b == st.samples[0])
        else $error("phase B path did not take phase A voltage");
    AST_ROUTE_C: assert property (@(posedge clk) disable iff (!rst_sync_n)
        set_ready && st.setup[13:12] == 2'b11 |=> path.c == st.samples[4])
        else $error("phase C path did not keep its own voltage");

    CVR_SET: cover property (@(posedge clk) disable iff (!rst_sync_n)
        set_ready ##1 st.ready_flag);
    CVR_PULSE: cover property (@(posedge clk) disable iff (!rst_sync_n)
        $rose(shared_ready_pin_n));
    CVR_CLEAR: cover property (@(posedge clk) disable iff (!rst_sync_n)
        st.ready_flag && clr_ready);
    CVR_ROUTE: cover property (@(posedge clk) disable iff (!rst_sync_n)
        path.valid && st.setup[13:8] != 6'h00);

endmodule : vcd_top

// >>> vcd_top_tb_top.sv
`timescale 1ns/1ps
`include "vcd_cfg.svh"

module vcd_top_tb_top;
    import vcd_pkg::*;

    // ------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------
    logic              clk;
    logic              rstn;
    vcd_adc_t          adc;
    vcd_req_t          req;
    vcd_rsp_t          rsp;
    vcd_path_t         path;
    logic              irq_n;
    logic              pin_n;
    int                num_errors;
    int                comparisons;
    int                cycles;
    int                dly;
    int                wid;
    vcd_path_t         got_path;
    logic [7:0][31:0]  words;
    logic [31:0]       d;
    vcd_words_t        w;
    // Rows: gain, converter sample, expected scaled sample
    logic [71:0]       rows [6] = '{72'h400000_100000_180000, 72'hc00000_100000_080000,
                                    72'h400000_f00000_e80000, 72'h800000_100000_000000,
                                    72'h7fffff_400000_7fffff, 72'h000000_abcdef_abcdef};
    // Channel index chosen by each route code for paths A, B, C
    int                ia [4] = '{0, 2, 4, 0};
    int                ib [4] = '{2, 4, 0, 2};
    int                ic [4] = '{4, 0, 2, 4};

    vcd_top u_dut (
        .clk                      (clk),
        .rstn                     (rstn),
        .adc                      (adc),
        .req                      (req),
        .rsp                      (rsp),
        .path                     (path),
        .first_interrupt_output_n (irq_n),
        .shared_ready_pin_n       (pin_n)
    );

    vcd_host_model u_host (
        .clk (clk),
        .rsp (rsp),
        .req (req)
    );

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run needs about 12500 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Read a register and insist that the answer came
    task automatic rd(input logic [15:0] a, output logic [31:0] data);
        logic v;
        u_host.read_reg(a, data, v);
        chk("read valid", 32'h1, {31'h0, v});
    endtask : rd

    // One sample set; measures ready pin delay and low width
    task automatic send_set(input vcd_words_t s);
        @(negedge clk);
        adc = '{valid: 1'b1, samples: s};
        @(negedge clk);
        adc = '{valid: 1'b0, samples: ~s};
        dly = 1;
        while (path.valid !== 1'b1 && dly < 20) begin
            @(negedge clk);
            dly++;
        end
        got_path = path;
        while (pin_n !== 1'b0 && dly < 40) begin
            @(negedge clk);
            dly++;
        end
        wid = 0;
        while (pin_n === 1'b0 && wid < 1100) begin
            @(negedge clk);
            wid++;
        end
    endtask : send_set

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        adc = '0;
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        // Reset values and an unmapped place
        rd(`VCD_OFS_SETUP, d);
        chk("setup reset", 32'h0000_0010, d);
        rd(`VCD_OFS_MASK, d);
        chk("mask reset", 32'h0, d);
        rd(16'he600, d);
        chk("unmapped read", 32'h0, d);
        // Filters off, pin function 00, default routes
        u_host.drive(1'b1, `VCD_OFS_SETUP, 32'h0);
        for (int i = 0; i < 6; i++) begin
            for (int c = 0; c < `VCD_NUM_CHAN; c++) begin
                u_host.drive(1'b1, `VCD_OFS_GAIN_BASE + 16'(c), {8'h00, rows[i][71:48]});
                rd(`VCD_OFS_GAIN_BASE + 16'(c), d);
                chk("gain read", {4'h0, {4{rows[i][71]}}, rows[i][71:48]}, d);
            end
            send_set({8{rows[i][47:24]}});
            // Two pipeline cycles to the flag, then the pin delay
            chk("pin delay", 32'(`VCD_READY_DELAY_CYC + 2), 32'(dly));
            chk("pin width", 32'd1000, 32'(wid));
            chk("path a", {8'h00, rows[i][23:0]}, {8'h00, got_path.a});
            chk("irq masked", 32'h1, {31'h0, irq_n});
            u_host.burst_read(words);
            for (int c = 0; c < `VCD_NUM_CHAN; c++) begin
                chk("sample", {{8{rows[i][23]}}, rows[i][23:0]}, words[c]);
            end
            rd(`VCD_OFS_STATUS, d);
            chk("ready flag", 32'h0002_0000, d & 32'h0002_0000);
        end
        // Unity gains, interrupt enabled, every route code
        for (int c = 0; c < `VCD_NUM_CHAN; c++) begin
            u_host.drive(1'b1, `VCD_OFS_GAIN_BASE + 16'(c), 32'h0);
        end
        u_host.drive(1'b1, `VCD_OFS_MASK, 32'h0002_0000);
        for (int k = 0; k < 4; k++) begin
            for (int c = 0; c < `VCD_NUM_CHAN; c++) begin
                w[c] = 24'h000111 * 24'(c + 1);
            end
            u_host.drive(1'b1, `VCD_OFS_SETUP, 32'((k << 8) | (k << 10) | (k << 12)));
            send_set(w);
            chk("route a", {8'h00, w[ia[k]]}, {8'h00, got_path.a});
            chk("route b", {8'h00, w[ib[k]]}, {8'h00, got_path.b});
            chk("route c", {8'h00, w[ic[k]]}, {8'h00, got_path.c});
            chk("irq set", 32'h0, {31'h0, irq_n});
            u_host.drive(1'b1, `VCD_OFS_STATUS, 32'h0002_0000);
            chk("irq release", 32'h1, {31'h0, irq_n});
            rd(`VCD_OFS_STATUS, d);
            chk("flag clear", 32'h0, d & 32'h0002_0000);
        end
        // Filters on: a steady negative level is pulled toward zero
        u_host.drive(1'b1, `VCD_OFS_SETUP, 32'h0000_0010);
        send_set({8{24'hf00000}});
        d = {8'h00, got_path.a};
        send_set({8{24'hf00000}});
        chk("hpf pulls to zero", 32'h1, {31'h0, $signed(got_path.a) > $signed(d[23:0])});
        chk("hpf sign", 32'h1, {31'h0, got_path.a[23]});
        u_host.burst_read(words);
        chk("sample at filter out", {{8{got_path.a[23]}}, got_path.a}, words[0]);
        // Reset in mid run clears live flag and interrupt
        @(negedge clk);
        rstn = 1'b0;
        @(negedge clk);
        chk("irq in reset", 32'h1, {31'h0, irq_n});
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        rd(`VCD_OFS_STATUS, d);
        chk("flag after reset", 32'h0, d & 32'h0002_0000);
        rd(`VCD_OFS_SETUP, d);
        chk("setup after reset", 32'h0000_0010, d);
        stop_test();
    end

endmodule : vcd_top_tb_top
